// ===== rtl/sync_serial_shift_port.sv
// Synchronous serial shift port with an APB register slave, master or slave shift clock.
// Assumes an APB master on clk, pins that are asynchronous, and port logic for the plain
// I/O function of the serial output pin.
`timescale 1ns/100ps
`include "sync_serial_map.svh"

module sync_serial_shift_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        sin_i,
  output logic             sout_o,
  output logic             sout_oe,
  input  wire logic        port_sout_level,
  input  wire logic        port_sout_oe,
  output logic             irq
);
  logic [7:0]                  ctrl;
  logic [7:0]                  frame;
  logic [7:0]                  route;
  logic [7:0]                  shifter;
  sync_serial_pkg::shift_state_t state;
  logic [3:0]                  bit_cnt;
  logic                        sck_reg;
  logic                        sck_prev;
  logic                        sout_bit;
  logic                        sin_lvl;
  logic                        sck_lvl;
  logic                        wr_go;
  logic                        mapped;
  logic                        is_master;
  logic                        lead;
  logic                        trail;
  logic                        capture;
  logic                        change;
  logic                        last_cap;
  logic                        done_evt;
  logic                        abort_evt;
  logic                        in_bit;
  logic [3:0]                  frame_len;

  shift_tick_if tk ();

  // True when the APB address hits the register with the given index.
  function automatic logic hits(input logic [11:0] addr, input logic [7:0] idx);
    hits = (addr == {2'b00, idx, 2'b00});
  endfunction : hits

  input_noise_filter u_sin_filter (
    .clk    (clk),
    .rst    (rst),
    .pin    (sin_i),
    .bypass (ctrl[`SSP_CTRL_FILT_DIS]),
    .level  (sin_lvl)
  );

  input_noise_filter u_sck_filter (
    .clk    (clk),
    .rst    (rst),
    .pin    (sck_i),
    .bypass (ctrl[`SSP_CTRL_FILT_DIS]),
    .level  (sck_lvl)
  );

  shift_clock_divider u_divider (
    .clk (clk),
    .rst (rst),
    .tk  (tk)
  );

  // The divider runs only during a master transfer at the programmed rate.
  assign is_master = ctrl[`SSP_CTRL_CLK_SRC];
  assign tk.run    = is_master && (state == sync_serial_pkg::S_SHIFT);
  assign tk.rate   = frame[`SSP_FRAME_RATE_MSB:`SSP_FRAME_RATE_LSB];
  assign frame_len = frame[`SSP_FRAME_LEN_MSB:`SSP_FRAME_LEN_LSB];

  // APB decode; a write or read completes in the access cycle with pready high.
  assign wr_go  = psel && penable && pready && pwrite;
  assign mapped = hits(paddr, `SSP_IDX_DATA) || hits(paddr, `SSP_IDX_FRAME) ||
                  hits(paddr, `SSP_IDX_CTRL) || hits(paddr, `SSP_IDX_ROUTE);

  // Shift edges: master edges come from divider ticks, slave edges from the filtered pin.
  always_comb begin
    if (is_master) begin
      lead  = tk.tick && (sck_reg == ctrl[`SSP_CTRL_CLOCK_POLARITY_SELECT]);
      trail = tk.tick && (sck_reg != ctrl[`SSP_CTRL_CLOCK_POLARITY_SELECT]);
    end else begin
      lead  = (state == sync_serial_pkg::S_SHIFT) && (sck_lvl != sck_prev) &&
              (sck_lvl != ctrl[`SSP_CTRL_CLOCK_POLARITY_SELECT]);
      trail = (state == sync_serial_pkg::S_SHIFT) && (sck_lvl != sck_prev) &&
              (sck_lvl == ctrl[`SSP_CTRL_CLOCK_POLARITY_SELECT]);
    end
  end

  // Phase picks which edge captures and which lets the output change.
  assign capture  = ctrl[`SSP_CTRL_CLOCK_PHASE_SELECT] ? trail : lead;
  assign change   = ctrl[`SSP_CTRL_CLOCK_PHASE_SELECT] ? lead : trail;
  assign last_cap = capture && (bit_cnt == frame_len - 4'h1);
  assign in_bit   = ctrl[`SSP_CTRL_SPIN] ? sin_lvl : 1'b0;

  // The frame ends after its last bit; a master also returns its clock to idle first.
  always_comb begin
    if (is_master && !ctrl[`SSP_CTRL_CLOCK_PHASE_SELECT]) begin
      done_evt = trail && (bit_cnt == frame_len);
    end else begin
      done_evt = last_cap;
    end
  end
  assign abort_evt = (state != sync_serial_pkg::S_IDLE) && !ctrl[`SSP_CTRL_RUN];

  // Transfer control register; hardware clears run when a frame completes.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `SSP_RST_CTRL;
    end else if (wr_go && hits(paddr, `SSP_IDX_CTRL)) begin
      ctrl <= pwdata[7:0];
    end else if (done_evt) begin
      ctrl[`SSP_CTRL_RUN] <= 1'b0;
    end
  end

  // Frame register; settings are frozen during a run while the done flag set beats a clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      frame <= `SSP_RST_FRAME;
    end else begin
      if (wr_go && hits(paddr, `SSP_IDX_FRAME) && !ctrl[`SSP_CTRL_RUN]) begin
        frame[`SSP_FRAME_LEN_MSB:`SSP_FRAME_RATE_LSB] <= pwdata[6:0];
      end
      if (done_evt || abort_evt) begin
        frame[`SSP_FRAME_DONE] <= 1'b1;
      end else if (wr_go && hits(paddr, `SSP_IDX_FRAME) && !pwdata[`SSP_FRAME_DONE]) begin
        frame[`SSP_FRAME_DONE] <= 1'b0;
      end
    end
  end

  // Output routing register.
  always_ff @(posedge clk) begin
    if (rst) begin
      route <= `SSP_RST_ROUTE;
    end else if (wr_go && hits(paddr, `SSP_IDX_ROUTE)) begin
      route <= pwdata[7:0];
    end
  end

  // Shift register: loaded by software when idle, shifted left on each capture edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      shifter <= 8'h00;
    end else if (wr_go && hits(paddr, `SSP_IDX_DATA) && !ctrl[`SSP_CTRL_RUN]) begin
      shifter <= pwdata[7:0];
    end else if (capture) begin
      shifter <= {shifter[6:0], in_bit};
    end
  end

  // Sequencer: start at once or on the external start level, stop on completion or abort.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sync_serial_pkg::S_IDLE;
    end else begin
      case (state)
        sync_serial_pkg::S_IDLE: begin
          if (ctrl[`SSP_CTRL_RUN]) begin
            state <= ctrl[`SSP_CTRL_EXT_START] ? sync_serial_pkg::S_ARM
                                                : sync_serial_pkg::S_SHIFT;
          end
        end
        sync_serial_pkg::S_ARM: begin
          if (abort_evt) begin
            state <= sync_serial_pkg::S_IDLE;
          end else if (sin_lvl) begin
            state <= sync_serial_pkg::S_SHIFT;
          end
        end
        sync_serial_pkg::S_SHIFT: begin
          if (abort_evt || done_evt) begin
            state <= sync_serial_pkg::S_IDLE;
          end
        end
        default: begin
          state <= sync_serial_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Capture edges counted per frame; a falling input level no longer matters once shifting.
  always_ff @(posedge clk) begin
    if (rst || state != sync_serial_pkg::S_SHIFT) begin
      bit_cnt <= 4'h0;
    end else if (capture) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Master clock level; idles at the polarity level and toggles on each tick.
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_reg <= 1'b0;
    end else if (state != sync_serial_pkg::S_SHIFT) begin
      sck_reg <= ctrl[`SSP_CTRL_CLOCK_POLARITY_SELECT];
    end else if (tk.tick) begin
      sck_reg <= !sck_reg;
    end
  end

  // Previous filtered clock level for slave edge detection.
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_lvl;
    end
  end

  // Serial output bit: bit 7 at load in phase zero, else on the change edges.
  always_ff @(posedge clk) begin
    if (rst) begin
      sout_bit <= 1'b0;
    end else if (state != sync_serial_pkg::S_SHIFT && !ctrl[`SSP_CTRL_CLOCK_PHASE_SELECT]) begin
      sout_bit <= shifter[7];
    end else if (change) begin
      sout_bit <= shifter[7];
    end
  end

  // Pin drivers: clock pin driven push-pull in master mode, output pin per routing bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_o   <= 1'b0;
      sck_oe  <= 1'b0;
      sout_o  <= 1'b0;
      sout_oe <= 1'b0;
    end else begin
      sck_o   <= sck_reg;
      sck_oe  <= is_master;
      sout_o  <= route[`SSP_ROUTE_EN] ? sout_bit : port_sout_level;
      sout_oe <= route[`SSP_ROUTE_EN] ? 1'b1 : port_sout_oe;
    end
  end

  // Interrupt request follows the done flag, gated by the enable bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= frame[`SSP_FRAME_DONE] && ctrl[`SSP_CTRL_IRQ_EN];
    end
  end

  // APB answer: data and status are set up in the setup cycle and stand for the access cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        if (hits(paddr, `SSP_IDX_DATA)) begin
          prdata <= {24'h00_0000, shifter};
        end else if (hits(paddr, `SSP_IDX_FRAME)) begin
          prdata <= {24'h00_0000, frame};
        end else if (hits(paddr, `SSP_IDX_CTRL)) begin
          prdata <= {24'h00_0000, ctrl};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  property p_reset_ctrl;
    @(posedge clk) rst |=> (ctrl == 8'h00);
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("control register not zero after reset");

  property p_done_clears_run;
    @(posedge clk) disable iff (rst)
      (done_evt && !(wr_go && hits(paddr, `SSP_IDX_CTRL))) |=>
        (!ctrl[`SSP_CTRL_RUN] && frame[`SSP_FRAME_DONE] && state == sync_serial_pkg::S_IDLE);
  endproperty
  a_done_clears_run: assert property (p_done_clears_run) else $error("completion did not end the run");

  property p_abort_flags;
    @(posedge clk) disable iff (rst)
      abort_evt |=> (frame[`SSP_FRAME_DONE] && state == sync_serial_pkg::S_IDLE);
  endproperty
  a_abort_flags: assert property (p_abort_flags) else $error("abort did not stop and flag");

  property p_irq_masked;
    @(posedge clk) disable iff (rst)
      irq |-> ($past(ctrl[`SSP_CTRL_IRQ_EN]) && $past(frame[`SSP_FRAME_DONE]));
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while masked");

  property p_data_write_ignored;
    @(posedge clk) disable iff (rst)
      (wr_go && hits(paddr, `SSP_IDX_DATA) && ctrl[`SSP_CTRL_RUN] && !capture) |=>
        (shifter == $past(shifter));
  endproperty
  a_data_write_ignored: assert property (p_data_write_ignored) else $error("data write during run");

  property p_master_drives_clock;
    @(posedge clk) disable iff (rst)
      is_master ##1 is_master |-> sck_oe;
  endproperty
  a_master_drives_clock: assert property (p_master_drives_clock) else $error("master not driving clock");

  property p_immediate_start;
    @(posedge clk) disable iff (rst)
      (state == sync_serial_pkg::S_IDLE && ctrl[`SSP_CTRL_RUN] && !ctrl[`SSP_CTRL_EXT_START]) |=>
        (state == sync_serial_pkg::S_SHIFT);
  endproperty
  a_immediate_start: assert property (p_immediate_start) else $error("run did not start transfer");

  property p_ext_start_waits;
    @(posedge clk) disable iff (rst)
      (state == sync_serial_pkg::S_ARM && !sin_lvl && ctrl[`SSP_CTRL_RUN]) |=>
        (state == sync_serial_pkg::S_ARM);
  endproperty
  a_ext_start_waits: assert property (p_ext_start_waits) else $error("started without input level");

  property p_phase0_load;
    @(posedge clk) disable iff (rst)
      (state == sync_serial_pkg::S_IDLE && !ctrl[`SSP_CTRL_CLOCK_PHASE_SELECT]) ##1 (state == sync_serial_pkg::S_SHIFT) |->
        (sout_bit == $past(shifter[7]));
  endproperty
  a_phase0_load: assert property (p_phase0_load) else $error("bit 7 not shown at load");

  property p_route_output;
    @(posedge clk) disable iff (rst)
      route[`SSP_ROUTE_EN] |=> (sout_oe && sout_o == $past(sout_bit));
  endproperty
  a_route_output: assert property (p_route_output) else $error("shifter not routed to output");
endmodule : sync_serial_shift_port

// ===== rtl/sync_serial_map.svh
// Register map, field positions, reset values and divider counts of the serial shift port.
// Assumes inclusion by the port's design files and by its bench; holds definitions and nothing else.
`ifndef SYNC_SERIAL_MAP_SVH
`define SYNC_SERIAL_MAP_SVH

// Register indices; the APB byte address is four times the index.
`define SSP_IDX_DATA       8'he0
`define SSP_IDX_FRAME      8'he1
`define SSP_IDX_CTRL       8'he2
`define SSP_IDX_ROUTE      8'hdd

// Fields of transfer_control_reg.
`define SSP_CTRL_RUN       7
`define SSP_CTRL_IRQ_EN    6
`define SSP_CTRL_CLOCK_PHASE_SELECT      5
`define SSP_CTRL_CLK_SRC   4
`define SSP_CTRL_SPIN      3
`define SSP_CTRL_EXT_START 2
`define SSP_CTRL_FILT_DIS  1
`define SSP_CTRL_CLOCK_POLARITY_SELECT      0

// Fields of the frame register.
`define SSP_FRAME_DONE     7
`define SSP_FRAME_LEN_MSB  6
`define SSP_FRAME_LEN_LSB  3
`define SSP_FRAME_RATE_MSB 2
`define SSP_FRAME_RATE_LSB 0

// Field of output_routing_reg.
`define SSP_ROUTE_EN       0

// Reset values.
`define SSP_RST_CTRL       8'h00
`define SSP_RST_FRAME      8'h00
`define SSP_RST_ROUTE      8'h00

// Core clock division that forms the base clock in master mode.
`define SSP_PRESCALE       13

`endif

// ===== rtl/sync_serial_pkg.sv
// Types shared by the serial shift port files.
// Assumes nothing beyond a SystemVerilog compiler.
package sync_serial_pkg;

  // Sequencer states of the shift engine.
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ARM   = 2'b01,
    S_SHIFT = 2'b10
  } shift_state_t;

endpackage : sync_serial_pkg

// ===== rtl/shift_tick_if.sv
// Connection between the shift engine and its shift clock divider.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface shift_tick_if;
  logic       run;   // Divider counts only while high.
  logic [2:0] rate;  // Bit rate selection.
  logic       tick;  // One-cycle pulse per shift clock half period.

  modport engine (output run, output rate, input tick);
  modport gen    (input run, input rate, output tick);
endinterface : shift_tick_if

// ===== rtl/input_noise_filter.sv
// Two-stage synchroniser with an optional glitch filter for one pin.
// Assumes an asynchronous pin level and one core clock.
`timescale 1ns/100ps
module input_noise_filter (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic bypass,
  output logic      level
);
  logic sync_a;
  logic sync_b;
  logic sync_c;

  // Bring the pin into the clock domain; only the second stage reads the first.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // A new level is taken only once it has held for two samples, so one-cycle pulses vanish.
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
    end else if (bypass) begin
      level <= sync_b;
    end else if (sync_b == sync_c) begin
      level <= sync_b;
    end
  end
endmodule : input_noise_filter

// ===== rtl/shift_clock_divider.sv
// Master shift clock divider: core clock by the prescale, then by the bit rate ratio.
// Assumes the engine holds run low outside a master transfer, which restarts the counts.
`timescale 1ns/100ps
`include "sync_serial_map.svh"
module shift_clock_divider #(
  parameter int PRESCALE = `SSP_PRESCALE
) (
  input  wire logic clk,
  input  wire logic rst,
  shift_tick_if.gen tk
);
  logic [7:0] pre_cnt;
  logic [8:0] rate_cnt;
  logic       pre_wrap;

  // Refuse at elaboration a prescale that the eight-bit counter cannot hold.
  if (PRESCALE < 1 || PRESCALE > 256) begin : g_bad_prescale
    $error("shift_clock_divider: PRESCALE must lie between 1 and 256");
  end

  // Ratio of base clock periods per tick for each rate code.
  function automatic logic [8:0] rate_ratio(input logic [2:0] code);
    rate_ratio = (code == 3'h7) ? 9'h100 : (9'h001 << code);
  endfunction : rate_ratio

  assign pre_wrap = (pre_cnt == 8'(PRESCALE - 1));

  // Count core cycles into base clock steps and base steps into ticks.
  always_ff @(posedge clk) begin
    if (rst || !tk.run) begin
      pre_cnt  <= 8'h00;
      rate_cnt <= 9'h000;
      tk.tick  <= 1'b0;
    end else begin
      tk.tick <= 1'b0;
      pre_cnt <= pre_wrap ? 8'h00 : pre_cnt + 8'h01;
      if (pre_wrap) begin
        if (rate_cnt == rate_ratio(tk.rate) - 9'h001) begin
          rate_cnt <= 9'h000;
          tk.tick  <= 1'b1;
        end else begin
          rate_cnt <= rate_cnt + 9'h001;
        end
      end
    end
  end
endmodule : shift_clock_divider

// ===== verif/spi_peer_model.sv
// Behavioural far-side peer of the serial shift port: swaps one frame per enable.
// Assumes clock idle low: it samples on the rising clock and changes data on the falling one.
`timescale 1ns/100ps
module spi_peer_model (
  input  wire logic       sck,
  input  wire logic       sout,
  input  wire logic       en,
  input  wire logic [7:0] tx_byte,
  output logic            sin,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh;
  logic       held;

  // Before the first frame the released line rests low.
  initial held = 1'b0;

  // Loads the outgoing byte when a frame opens, so its top bit is on the line at once.
  always @(posedge en) begin
    sh = tx_byte;
    rx_byte = 8'h00;
  end
  // Captures the port's output, top bit first, on the rising clock.
  always @(posedge sck) if (en) rx_byte = {rx_byte[6:0], sout};
  // Moves on to the next bit on the falling clock.
  always @(negedge sck) if (en) sh = {sh[6:0], ~sh[7]};
  // Outside a frame the line shows the inverse of its last level, never a stale copy.
  always @(negedge en) held = ~sh[7];
  assign sin = en ? sh[7] : held;
endmodule : spi_peer_model

// ===== verif/tb.sv
// Self-checking bench of the serial shift port: APB master tasks, a far-side peer, scenarios.
// Assumes the port's design files and the peer model are compiled before it.
`timescale 1ns/100ps
`include "sync_serial_map.svh"
module tb;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, pe, irq;
  logic        sck_o, sck_oe, sck_q, sin, sout_o, sout_oe, port_lvl, port_oe, peer_en, sck_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  peer_tx, peer_rx;
  int          error_cnt, checks_done, cyc, hc, half, rises, nr, sl_edges;

  sync_serial_shift_port sync_serial_shift_port_inst (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_i(sck_in),
    .sck_o(sck_o), .sck_oe(sck_oe), .sin_i(sin), .sout_o(sout_o), .sout_oe(sout_oe),
    .port_sout_level(port_lvl), .port_sout_oe(port_oe), .irq(irq));
  // The peer sees the port's clock while the port drives the shared clock pin, else the bench's.
  spi_peer_model spi_peer_model_inst (.sck(sck_oe ? sck_o : sck_in), .sout(sout_o), .en(peer_en),
    .tx_byte(peer_tx), .sin(sin), .rx_byte(peer_rx));

  // Bench as an external clock master: a set number of pin toggles, one every eight cycles.
  always @(posedge clk) begin
    if (sl_edges > 0 && cyc % 8 == 0) begin
      sck_in <= ~sck_in;
      sl_edges <= sl_edges - 1;
    end
  end

  // Core clock of 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Counts cycles, measures the shift clock half period and counts its rising edges.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hc <= hc + 1;
    sck_q <= sck_o;
    if (sck_o !== sck_q) begin
      half <= hc + 1;
      hc <= 0;
      if (sck_o === 1'b1) rises <= rises + 1;
    end
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // One APB transfer; holds the request until pready is sampled high, then takes the answer.
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls the run flag until it drops; a flag that never drops counts as a mismatch.
  task automatic poll_idle();
    int n;
    n = 0;
    do begin
      apb(`SSP_IDX_CTRL, 1'b0, 8'h00);
      n++;
    end while (rd[7] !== 1'b0 && n < 400);
    chk("run_cleared", {31'h0, rd[7]}, 32'h0000_0000);
  endtask : poll_idle

  // Runs one frame and polls the run flag until it drops.
  task automatic xfer(input logic [7:0] d, input logic [7:0] fr, input logic [7:0] ct);
    int r0;
    apb(`SSP_IDX_DATA, 1'b1, d);
    apb(`SSP_IDX_FRAME, 1'b1, fr);
    peer_en <= 1'b1;
    r0 = rises;
    apb(`SSP_IDX_CTRL, 1'b1, ct);
    apb(`SSP_IDX_DATA, 1'b1, 8'hff);
    poll_idle();
    nr = rises - r0;
    peer_en <= 1'b0;
  endtask : xfer

  // Reset values and an unmapped address.
  task automatic t_reset();
    apb(`SSP_IDX_CTRL, 1'b0, 8'h00);
    chk("ctrl_reset", rd, 32'h0000_0000);
    apb(8'h10, 1'b0, 8'h00);
    chk("unmapped_err", {31'h0, pe}, 32'h0000_0001);
    chk("irq_idle", {31'h0, irq}, 32'h0000_0000);
  endtask : t_reset

  // Output pin as a plain port line, then as the shifter's top bit.
  task automatic t_route();
    apb(`SSP_IDX_ROUTE, 1'b1, 8'h00);
    port_lvl <= 1'b1;
    port_oe <= 1'b1;
    repeat (3) @(posedge clk);
    chk("plain_level", {31'h0, sout_o}, 32'h0000_0001);
    chk("plain_oe", {31'h0, sout_oe}, 32'h0000_0001);
    port_lvl <= 1'b0;
    apb(`SSP_IDX_ROUTE, 1'b1, 8'h01);
    apb(`SSP_IDX_DATA, 1'b1, 8'ha5);
    repeat (3) @(posedge clk);
    chk("msb_at_load", {31'h0, sout_o}, 32'h0000_0001);
  endtask : t_route

  // Full master frame, input pin shifted in, interrupt enabled.
  task automatic t_master();
    peer_tx <= 8'h3c;
    xfer(8'ha5, 8'h40, 8'hd8);
    chk("peer_rx", {24'h00_0000, peer_rx}, 32'h0000_00a5);
    chk("edges8", nr, 8);
    chk("half13", half, 13);
    chk("clk_oe", {31'h0, sck_oe}, 32'h0000_0001);
    chk("irq_on", {31'h0, irq}, 32'h0000_0001);
    apb(`SSP_IDX_DATA, 1'b0, 8'h00);
    chk("rx_data", rd, 32'h0000_003c);
    apb(`SSP_IDX_FRAME, 1'b0, 8'h00);
    chk("done_set", rd, 32'h0000_00c0);
  endtask : t_master

  // Short frame at half rate with zeros shifted in and the interrupt masked.
  task automatic t_short();
    xfer(8'ha5, 8'h21, 8'h90);
    chk("edges4", nr, 4);
    chk("half26", half, 26);
    chk("peer_rx4", {24'h00_0000, peer_rx}, 32'h0000_000a);
    chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
    apb(`SSP_IDX_DATA, 1'b0, 8'h00);
    chk("zero_fill", rd, 32'h0000_0050);
    apb(`SSP_IDX_FRAME, 1'b0, 8'h00);
    chk("done4", rd, 32'h0000_00a1);
  endtask : t_short

  // Abort of a slow frame by clearing run, then clearing the done flag.
  task automatic t_abort();
    apb(`SSP_IDX_FRAME, 1'b1, 8'h47);
    apb(`SSP_IDX_CTRL, 1'b1, 8'hd0);
    repeat (40) @(posedge clk);
    apb(`SSP_IDX_CTRL, 1'b1, 8'h50);
    apb(`SSP_IDX_FRAME, 1'b0, 8'h00);
    chk("abort_done", rd, 32'h0000_00c7);
    chk("abort_irq", {31'h0, irq}, 32'h0000_0001);
    apb(`SSP_IDX_FRAME, 1'b1, 8'h47);
    repeat (3) @(posedge clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0000_0000);
  endtask : t_abort

  // Idle level of the shift clock follows the polarity bit.
  task automatic t_pol();
    apb(`SSP_IDX_CTRL, 1'b1, 8'h11);
    repeat (3) @(posedge clk);
    chk("idle_high", {31'h0, sck_o}, 32'h0000_0001);
    apb(`SSP_IDX_CTRL, 1'b1, 8'h10);
    repeat (3) @(posedge clk);
    chk("idle_low", {31'h0, sck_o}, 32'h0000_0000);
  endtask : t_pol

  // External start: the frame waits for the input level, then runs on after that level falls.
  task automatic t_ext();
    int r0;
    peer_tx <= 8'h00;
    peer_en <= 1'b1;
    apb(`SSP_IDX_FRAME, 1'b1, 8'h20);
    r0 = rises;
    apb(`SSP_IDX_CTRL, 1'b1, 8'h94);
    repeat (40) @(posedge clk);
    chk("ext_wait", rises - r0, 0);
    peer_en <= 1'b0;
    @(posedge clk);
    peer_tx <= 8'h80;
    peer_en <= 1'b1;
    poll_idle();
    peer_en <= 1'b0;
    chk("ext_edges", rises - r0, 4);
    chk("ext_rx", {24'h00_0000, peer_rx}, 32'h0000_0005);
  endtask : t_ext

  // Slave frame: the bench clocks the pin, the port leaves its clock pin released, filters bypassed.
  task automatic t_slave();
    apb(`SSP_IDX_DATA, 1'b1, 8'hc3);
    apb(`SSP_IDX_FRAME, 1'b1, 8'h40);
    peer_tx <= 8'h96;
    peer_en <= 1'b1;
    apb(`SSP_IDX_CTRL, 1'b1, 8'h8a);
    sl_edges <= 16;
    poll_idle();
    peer_en <= 1'b0;
    chk("slave_oe", {31'h0, sck_oe}, 32'h0000_0000);
    chk("slave_rx", {24'h00_0000, peer_rx}, 32'h0000_00c3);
    apb(`SSP_IDX_DATA, 1'b0, 8'h00);
    chk("slave_data", rd, 32'h0000_0096);
  endtask : t_slave

  // Main sequence: reset, then each scenario in turn.
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    port_lvl = 1'b0;
    port_oe = 1'b0;
    peer_en = 1'b0;
    peer_tx = 8'h3c;
    sck_in = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_master();
    t_short();
    t_abort();
    t_pol();
    t_ext();
    t_slave();
    close_out();
  end
endmodule : tb
